// >>> verilog/fxc_top.sv
// Host-side escape issue, fault vectors and coprocessor exception state.
// Assumes ports synchronous to ref_clk; one issue request per ready cycle.
//
// How it works
// RL1: Escape with task-switched or emulation flag set raises vector 7.
// RL2: Wait with task-switched flag set also raises vector 7.
// RL3: Operand tail beyond segment limit raises vector 9.
// RL4: Operand start beyond segment limit raises vector 13.
// RL5: Next escape waits until coprocessor busy clears; no explicit wait.
// RL6: Legacy interrupt enable and disable opcodes change nothing.
// RL7: Set-protected opcode is ignored.
// RL8: Saved instruction address points at first prefix byte.
// RL9: Protected mode saves no opcode and uses protected pointer layout.
// RL10: Environment store and state save layout follows current mode.
// RL11: Split of zero flags zero-divide and puts minus infinity in second register.
// RL12: Stack-fault bit marks invalid from stack underflow or overflow.
// RL13: Extended-precision load never reports denormal.
// RL14: Single or double denormal load flags denormal; signaling NaN flags invalid.
// RL15: Only quiet NaNs produced; compare and integer/decimal stores trap quiet NaNs.
// RL16: Square root, divide, remainder, conversions normalize denormals first.
// RL17: Infinity arithmetic is affine only, signed infinities.
// RL18: Constant loads use current rounding control.
// RL19: Software tag writes accepted only as empty; others recomputed.
// RL20: Pseudo and unnormal encodings are not valid data.
// RL21: Masked overflow or underflow result follows rounding mode.
// RL22: Denormal has no top priority; transcendental and split may flag it.
// RL23: Busy holds from acceptance until instruction finishes.
`default_nettype none
module fxc_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Machine status
    input wire logic task_switched_flag,
    input wire logic emulation_flag,
    input wire logic prot_mode,
    // Issue request
    input wire logic esc_req,
    input wire logic wait_req,
    input wire logic [3:0] esc_op,
    input wire logic [2:0] opnd_class,
    input wire logic [1:0] opnd_prec,
    input wire logic opnd_sign,
    input wire logic [15:0] opnd_start,
    input wire logic [15:0] opnd_last,
    input wire logic [15:0] seg_limit,
    input wire logic [15:0] instr_addr,
    input wire logic [15:0] prefix_addr,
    input wire logic has_prefix,
    input wire logic [10:0] opcode_in,
    input wire logic stack_err,
    input wire logic [1:0] round_ctl,
    input wire logic ovf_mask,
    input wire logic unf_mask,
    input wire logic ovf_evt,
    input wire logic unf_evt,
    input wire logic [2:0] tag_idx,
    input wire logic [1:0] tag_wdata,
    input wire logic [1:0] tag_actual,
    input wire logic sw_clear,
    // Issue answer
    output logic issue_ready,
    output logic accepted,
    output logic fault_valid,
    output logic [7:0] fault_vec,
    // Coprocessor state
    output logic busy,
    output logic [7:0] status_word,
    output logic [15:0] saved_ip,
    output logic [10:0] saved_opcode,
    output logic saved_layout,
    output logic [15:0] st1_hi,
    output logic [1:0] const_round,
    output logic [1:0] result_round,
    output logic [15:0] tag_word
);
    logic [7:0] sw_r;
    logic [7:0] sw_nxt;
    logic fv_r;
    logic [7:0] vec_r;
    logic acc_r;
    logic [15:0] ip_r;
    logic [10:0] opc_r;
    logic lay_r;
    logic [15:0] st1_r;
    logic [1:0] cr_r;
    logic [1:0] rr_r;
    logic [15:0] tag_r;
    logic c_inv;
    logic c_den;
    logic c_zdiv;
    logic c_norm;

    function automatic logic beyond(input logic [15:0] a, input logic [15:0] lim);
        beyond = (a > lim);
    endfunction

    fxc_busy_timer u_busy (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(accepted),
        .busy(busy)
    );

    fxc_exc_classify u_cls (
        .op(esc_op),
        .opnd_class(opnd_class),
        .opnd_prec(opnd_prec),
        .invalid(c_inv),
        .denorm(c_den),
        .zdiv(c_zdiv),
        .normalize(c_norm)
    );

    // Issue decode
    assign issue_ready = !busy; // see RL5
    wire esc_go = esc_req && issue_ready; // see RL5
    wire unavail = (esc_go && (task_switched_flag || emulation_flag)) || // see RL1
        (wait_req && task_switched_flag); // see RL2
    wire start_bad = esc_go && beyond(opnd_start, seg_limit); // see RL4
    wire tail_bad = esc_go && !beyond(opnd_start, seg_limit) &&
        beyond(opnd_last, seg_limit); // see RL3
    wire any_fault = unavail || start_bad || tail_bad;
    wire [7:0] vec_sel = unavail ? fxc_pkg::VEC_UNAVAIL :
        (start_bad ? fxc_pkg::VEC_GEN_PROT : fxc_pkg::VEC_SEG_OVERRUN);
    wire is_nop = (esc_op == fxc_pkg::OP_IRQ_ENABLE) || // see RL6
        (esc_op == fxc_pkg::OP_IRQ_DISABLE) || (esc_op == fxc_pkg::OP_SET_PROT); // see RL7
    assign accepted = esc_go && !any_fault;
    wire exec = accepted && !is_nop && (esc_op != fxc_pkg::OP_TAG_WRITE);
    wire tag_wr = accepted && (esc_op == fxc_pkg::OP_TAG_WRITE);
    wire env_op = (esc_op == fxc_pkg::OP_ENV_STORE) || (esc_op == fxc_pkg::OP_STATE_SAVE);

    // Status word next value; sticky until cleared, set wins over clear
    wire stack_inv = exec && stack_err; // see RL12
    wire inv_evt = (exec && c_inv) || stack_inv;
    wire ovf_hit = exec && ovf_evt;
    wire unf_hit = exec && unf_evt;
    always_comb begin
        sw_nxt = sw_clear ? fxc_pkg::SW_RESET : sw_r;
        if (inv_evt) sw_nxt[fxc_pkg::SW_INVALID] = 1'b1; // see RL15
        if (exec && c_den && !c_norm) sw_nxt[fxc_pkg::SW_DENORM] = 1'b1; // see RL22
        if (exec && c_zdiv) sw_nxt[fxc_pkg::SW_ZDIV] = 1'b1; // see RL11
        if (ovf_hit) sw_nxt[fxc_pkg::SW_OVER] = 1'b1;
        if (unf_hit) sw_nxt[fxc_pkg::SW_UNDER] = 1'b1;
        if (stack_inv) sw_nxt[fxc_pkg::SW_STACK] = 1'b1; // see RL12
    end

    // Saved pointers: prefix address when present, no opcode in protected mode
    wire [15:0] ip_sel = has_prefix ? prefix_addr : instr_addr; // see RL8
    wire [10:0] opc_sel = prot_mode ? 11'h000 : opcode_in; // see RL9
    wire lay_sel = prot_mode ? fxc_pkg::LAYOUT_PROT : fxc_pkg::LAYOUT_REAL; // see RL9, RL10
    // Affine model: infinity keeps its sign; split of zero gives minus infinity
    wire [15:0] st1_sel = (esc_op == fxc_pkg::OP_SPLIT && opnd_class == fxc_pkg::CL_ZERO) ?
        fxc_pkg::NEG_INF_HI : // see RL11
        (opnd_sign ? fxc_pkg::NEG_INF_HI : fxc_pkg::POS_INF_HI); // see RL17
    wire st1_upd = exec && ((esc_op == fxc_pkg::OP_SPLIT && opnd_class == fxc_pkg::CL_ZERO) ||
        opnd_class == fxc_pkg::CL_INF);
    // Tag write: empty kept, anything else takes the real register contents
    wire [1:0] tag_val = (tag_wdata == fxc_pkg::TAG_EMPTY) ? fxc_pkg::TAG_EMPTY :
        tag_actual; // see RL19
    wire [15:0] tag_mask = 16'h0003 << {tag_idx, 1'b0};
    wire [15:0] tag_nxt = (tag_r & ~tag_mask) | ({14'h0000, tag_val} << {tag_idx, 1'b0});
    wire mask_round = (ovf_hit && ovf_mask) || (unf_hit && unf_mask); // see RL21

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_r <= fxc_pkg::SW_RESET;
            fv_r <= 1'b0;
            vec_r <= 8'h00;
            acc_r <= 1'b0;
        end else begin
            sw_r <= sw_nxt;
            fv_r <= any_fault;
            vec_r <= any_fault ? vec_sel : vec_r;
            acc_r <= accepted;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ip_r <= 16'h0000;
            opc_r <= 11'h000;
            lay_r <= fxc_pkg::LAYOUT_REAL;
        end else if (exec && !env_op) begin
            ip_r <= ip_sel; // see RL8
            opc_r <= opc_sel; // see RL9
            lay_r <= lay_sel;
        end else if (accepted && env_op) begin
            lay_r <= lay_sel; // see RL10
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st1_r <= 16'h0000;
            cr_r <= 2'h0;
            rr_r <= 2'h0;
            tag_r <= 16'hFFFF;
        end else begin
            if (st1_upd) st1_r <= st1_sel;
            if (exec && esc_op == fxc_pkg::OP_LOAD_CONST) cr_r <= round_ctl; // see RL18
            if (mask_round) rr_r <= round_ctl; // see RL21
            if (tag_wr) tag_r <= tag_nxt; // see RL19
        end
    end

    assign status_word = sw_r;
    assign fault_valid = fv_r;
    assign fault_vec = vec_r;
    assign saved_ip = ip_r;
    assign saved_opcode = opc_r;
    assign saved_layout = lay_r;
    assign st1_hi = st1_r;
    assign const_round = cr_r;
    assign result_round = rr_r;
    assign tag_word = tag_r;

    a_unavail_vec: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (esc_req && !busy && (task_switched_flag || emulation_flag)) |=>
        fault_valid && fault_vec == 8'h07) else $error("vector 7 missing"); // see RL1
    a_wait_vec: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wait_req && task_switched_flag) |=> fault_valid && fault_vec == 8'h07)
        else $error("wait vector 7 missing"); // see RL2
    a_tail_vec: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (esc_req && !busy && !task_switched_flag && !emulation_flag && !wait_req &&
        opnd_start <= seg_limit && opnd_last > seg_limit) |=> fault_vec == 8'h09)
        else $error("vector 9 missing"); // see RL3
    a_start_vec: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (esc_req && !busy && !task_switched_flag && !emulation_flag && !wait_req &&
        opnd_start > seg_limit) |=> fault_vec == 8'h0D)
        else $error("vector 13 missing"); // see RL4
    a_no_issue_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
        busy |-> !accepted) else $error("issue while busy"); // see RL5
    a_nop_still: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (accepted && is_nop && !sw_clear) |=> $stable(status_word) && $stable(saved_ip))
        else $error("nop changed state"); // see RL6
    a_prot_noopc: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (exec && !env_op && prot_mode) |=> saved_opcode == 11'h000 && saved_layout)
        else $error("opcode saved in protected mode"); // see RL9
    a_split_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (exec && esc_op == fxc_pkg::OP_SPLIT && opnd_class == fxc_pkg::CL_ZERO) |=>
        status_word[2] && st1_hi == 16'hFFFF) else $error("split zero wrong"); // see RL11
    a_ext_noden: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (exec && esc_op == fxc_pkg::OP_LOAD && opnd_prec == fxc_pkg::PR_EXT &&
        !sw_r[1] && !sw_clear) |=> !status_word[1]) else $error("ext load denormal"); // see RL13
    a_stack_sf: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (exec && stack_err) |=> status_word[6] && status_word[0])
        else $error("stack fault not set"); // see RL12
    c_fault7: cover property (@(posedge ref_clk) disable iff (!rst_n)
        fault_valid && fault_vec == 8'h07);
    c_back_issue: cover property (@(posedge ref_clk) disable iff (!rst_n)
        accepted ##[1:8] accepted);
    c_split: cover property (@(posedge ref_clk) disable iff (!rst_n) exec && c_zdiv);
    c_tag: cover property (@(posedge ref_clk) disable iff (!rst_n) tag_wr);
endmodule
`default_nettype wire

// >>> verilog/fxc_pkg.sv
// Shared constants for the coprocessor exception and escape-issue block.
// Assumes a single 25 MHz clock and an active-low asynchronous reset.
`default_nettype none
package fxc_pkg;
    // Interrupt vectors raised by the host side
    localparam logic [7:0] VEC_UNAVAIL = 8'h07;
    localparam logic [7:0] VEC_SEG_OVERRUN = 8'h09;
    localparam logic [7:0] VEC_GEN_PROT = 8'h0D;
    // Instruction classes offered to the issue port
    localparam logic [3:0] OP_ARITH = 4'h0;
    localparam logic [3:0] OP_LOAD = 4'h1;
    localparam logic [3:0] OP_COMPARE = 4'h2;
    localparam logic [3:0] OP_INT_STORE = 4'h3;
    localparam logic [3:0] OP_DEC_STORE = 4'h4;
    localparam logic [3:0] OP_SQRT_DIV_REM = 4'h5;
    localparam logic [3:0] OP_SPLIT = 4'h6;
    localparam logic [3:0] OP_TRANSC = 4'h7;
    localparam logic [3:0] OP_LOAD_CONST = 4'h8;
    localparam logic [3:0] OP_IRQ_ENABLE = 4'h9;
    localparam logic [3:0] OP_IRQ_DISABLE = 4'hA;
    localparam logic [3:0] OP_SET_PROT = 4'hB;
    localparam logic [3:0] OP_ENV_STORE = 4'hC;
    localparam logic [3:0] OP_STATE_SAVE = 4'hD;
    localparam logic [3:0] OP_TAG_WRITE = 4'hE;
    // Operand classes
    localparam logic [2:0] CL_NORMAL = 3'h0;
    localparam logic [2:0] CL_ZERO = 3'h1;
    localparam logic [2:0] CL_DENORM = 3'h2;
    localparam logic [2:0] CL_QNAN = 3'h3;
    localparam logic [2:0] CL_SNAN = 3'h4;
    localparam logic [2:0] CL_INF = 3'h5;
    localparam logic [2:0] CL_PSEUDO = 3'h6;
    // Operand precision
    localparam logic [1:0] PR_SINGLE = 2'h0;
    localparam logic [1:0] PR_DOUBLE = 2'h1;
    localparam logic [1:0] PR_EXT = 2'h2;
    // Status word bit positions
    localparam int SW_INVALID = 0;
    localparam int SW_DENORM = 1;
    localparam int SW_ZDIV = 2;
    localparam int SW_OVER = 3;
    localparam int SW_UNDER = 4;
    localparam int SW_STACK = 6;
    localparam logic [7:0] SW_RESET = 8'h00;
    // Tag values
    localparam logic [1:0] TAG_VALID = 2'h0;
    localparam logic [1:0] TAG_ZERO = 2'h1;
    localparam logic [1:0] TAG_SPECIAL = 2'h2;
    localparam logic [1:0] TAG_EMPTY = 2'h3;
    // Pointer layout selector
    localparam logic LAYOUT_REAL = 1'b0;
    localparam logic LAYOUT_PROT = 1'b1;
    // Busy duration of an accepted escape instruction
    localparam int EXEC_TIME_NS = 200;
    localparam int CLK_PERIOD_NS = 40;
    localparam int EXEC_CYCLES = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] EXEC_CNT = 4'(EXEC_CYCLES);
    localparam logic [15:0] NEG_INF_HI = 16'hFFFF;
    localparam logic [15:0] POS_INF_HI = 16'h7FFF;
endpackage
`default_nettype wire

// >>> verilog/fxc_busy_timer.sv
// Busy timer: holds busy from acceptance until the instruction finishes.
// Assumes start pulses come only while busy is low.
`default_nettype none
module fxc_busy_timer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    output logic busy
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    assign cnt_nxt = start ? fxc_pkg::EXEC_CNT : (cnt_r != 4'h0 ? cnt_r - 4'h1 : 4'h0);
    assign busy = (cnt_r != 4'h0);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) cnt_r <= 4'h0; // see RL23
        else cnt_r <= cnt_nxt; // see RL23
    end
    a_busy_span: assert property (@(posedge ref_clk) disable iff (!rst_n)
        start |=> busy [*5] ##1 !busy) else $error("busy span wrong"); // see RL23
endmodule
`default_nettype wire

// >>> verilog/fxc_exc_classify.sv
// Numeric exception classifier for one instruction and operand class.
// Purely combinational; the caller registers the flags.
`default_nettype none
module fxc_exc_classify (
    // Instruction
    input wire logic [3:0] op,
    input wire logic [2:0] opnd_class,
    input wire logic [1:0] opnd_prec,
    // Flags
    output logic invalid,
    output logic denorm,
    output logic zdiv,
    output logic normalize
);
    wire is_snan = (opnd_class == fxc_pkg::CL_SNAN);
    wire is_qnan = (opnd_class == fxc_pkg::CL_QNAN);
    wire is_den = (opnd_class == fxc_pkg::CL_DENORM);
    wire is_load = (op == fxc_pkg::OP_LOAD);
    wire is_ext = (opnd_prec == fxc_pkg::PR_EXT);
    wire qnan_strict = (op == fxc_pkg::OP_COMPARE) || (op == fxc_pkg::OP_INT_STORE) ||
        (op == fxc_pkg::OP_DEC_STORE);
    wire norm_first = (op == fxc_pkg::OP_SQRT_DIV_REM) || (op == fxc_pkg::OP_INT_STORE) ||
        (op == fxc_pkg::OP_DEC_STORE);
    wire numeric = (op == fxc_pkg::OP_ARITH) || (op == fxc_pkg::OP_COMPARE) ||
        (op == fxc_pkg::OP_SQRT_DIV_REM) || (op == fxc_pkg::OP_SPLIT) ||
        (op == fxc_pkg::OP_TRANSC) || (op == fxc_pkg::OP_INT_STORE) ||
        (op == fxc_pkg::OP_DEC_STORE);
    // Signaling NaN (except on extended loads), pseudo encodings and strict quiet-NaN users are invalid
    assign invalid = ((numeric || (is_load && !is_ext)) && is_snan) || // see RL14, RL15
        (numeric && qnan_strict && is_qnan) || // see RL15
        ((numeric || is_load) && opnd_class == fxc_pkg::CL_PSEUDO); // see RL20
    // Extended loads are not numeric and never report denormal
    assign denorm = is_den && ((is_load && !is_ext) || numeric); // see RL13, RL14, RL22
    assign zdiv = (op == fxc_pkg::OP_SPLIT) && (opnd_class == fxc_pkg::CL_ZERO); // see RL11
    assign normalize = is_den && norm_first; // see RL16
endmodule
`default_nettype wire

// >>> bench/fxc_host_model.sv
// Host core model: offers one escape request per go pulse.
// Assumes go is pulsed only while no request is pending.
`default_nettype none
module fxc_host_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bench side
    input wire logic go,
    output logic done,
    // Coprocessor side
    input wire logic issue_ready,
    output logic esc_req
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            esc_req <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= esc_req && issue_ready;
            // Request held until busy clears
            if (esc_req && issue_ready) begin
                esc_req <= 1'b0;
            end else if (go) begin
                esc_req <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/fpu_coprocessor_exceptions_tb.sv
// Bench for escape issue, fault vectors and numeric exception state.
// Assumes the host model owns the escape request line.
`default_nettype none
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end
module fpu_coprocessor_exceptions_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0] op;
        logic [2:0] cl;
        logic [1:0] pr;
        logic se;
        logic [7:0] sw;
    } fxc_num_t;
    localparam fxc_num_t NUMS [13] = '{
        '{fxc_pkg::OP_LOAD, fxc_pkg::CL_DENORM, fxc_pkg::PR_EXT, 1'b0, 8'h00},
        '{fxc_pkg::OP_LOAD, fxc_pkg::CL_DENORM, fxc_pkg::PR_SINGLE, 1'b0, 8'h02},
        '{fxc_pkg::OP_LOAD, fxc_pkg::CL_DENORM, fxc_pkg::PR_DOUBLE, 1'b0, 8'h02},
        '{fxc_pkg::OP_LOAD, fxc_pkg::CL_SNAN, fxc_pkg::PR_DOUBLE, 1'b0, 8'h01},
        '{fxc_pkg::OP_COMPARE, fxc_pkg::CL_QNAN, fxc_pkg::PR_EXT, 1'b0, 8'h01},
        '{fxc_pkg::OP_INT_STORE, fxc_pkg::CL_QNAN, fxc_pkg::PR_EXT, 1'b0, 8'h01},
        '{fxc_pkg::OP_DEC_STORE, fxc_pkg::CL_QNAN, fxc_pkg::PR_EXT, 1'b0, 8'h01},
        '{fxc_pkg::OP_ARITH, fxc_pkg::CL_QNAN, fxc_pkg::PR_EXT, 1'b0, 8'h00},
        '{fxc_pkg::OP_ARITH, fxc_pkg::CL_SNAN, fxc_pkg::PR_EXT, 1'b0, 8'h01},
        '{fxc_pkg::OP_SQRT_DIV_REM, fxc_pkg::CL_DENORM, fxc_pkg::PR_EXT, 1'b0, 8'h00},
        '{fxc_pkg::OP_ARITH, fxc_pkg::CL_PSEUDO, fxc_pkg::PR_EXT, 1'b0, 8'h01},
        '{fxc_pkg::OP_ARITH, fxc_pkg::CL_NORMAL, fxc_pkg::PR_EXT, 1'b1, 8'h41},
        '{fxc_pkg::OP_TRANSC, fxc_pkg::CL_DENORM, fxc_pkg::PR_EXT, 1'b0, 8'h02}
    };
    localparam logic [3:0] NOPS [3] = '{fxc_pkg::OP_IRQ_ENABLE, fxc_pkg::OP_IRQ_DISABLE,
        fxc_pkg::OP_SET_PROT};
    logic ref_clk, rst_n, task_switched_flag, emulation_flag, prot_mode, esc_req, wait_req;
    logic opnd_sign, has_prefix, stack_err, ovf_mask, unf_mask, ovf_evt, unf_evt, sw_clear;
    logic issue_ready, accepted, fault_valid, busy, saved_layout, go, done;
    logic [3:0] esc_op;
    logic [2:0] opnd_class, tag_idx;
    logic [1:0] opnd_prec, round_ctl, tag_wdata, tag_actual, const_round, result_round;
    logic [15:0] opnd_start, opnd_last, seg_limit, instr_addr, prefix_addr, st1_hi, tag_word;
    logic [15:0] saved_ip;
    logic [10:0] opcode_in, saved_opcode;
    logic [7:0] fault_vec, status_word;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int t0;
    int n;
    fxc_top uut (
        .ref_clk, .rst_n, .task_switched_flag, .emulation_flag, .prot_mode, .esc_req,
        .wait_req, .esc_op, .opnd_class, .opnd_prec, .opnd_sign, .opnd_start, .opnd_last,
        .seg_limit, .instr_addr, .prefix_addr, .has_prefix, .opcode_in, .stack_err,
        .round_ctl, .ovf_mask, .unf_mask, .ovf_evt, .unf_evt, .tag_idx, .tag_wdata,
        .tag_actual, .sw_clear, .issue_ready, .accepted, .fault_valid, .fault_vec, .busy,
        .status_word, .saved_ip, .saved_opcode, .saved_layout, .st1_hi, .const_round,
        .result_round, .tag_word
    );
    fxc_host_model host (
        .ref_clk, .rst_n, .go, .done, .issue_ready, .esc_req
    );
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc++;
    always @(negedge ref_clk) begin
        if (busy === 1'b1) begin
            `CHK(accepted, 1'b0)
        end
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic issue(input logic [3:0] op, input logic [2:0] cl, input logic [1:0] pr);
        int k;
        @(posedge ref_clk);
        esc_op <= op;
        opnd_class <= cl;
        opnd_prec <= pr;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (done !== 1'b1 && k < 20);
        if (done !== 1'b1) begin
            num_errors++;
            give_verdict();
        end
    endtask
    task automatic clear();
        @(posedge ref_clk);
        sw_clear <= 1'b1;
        stack_err <= 1'b0;
        @(posedge ref_clk);
        sw_clear <= 1'b0;
    endtask
    task automatic fault_case(input logic ts, input logic em, input logic [15:0] st,
            input logic [15:0] la, input logic [7:0] vec);
        @(posedge ref_clk);
        task_switched_flag <= ts;
        emulation_flag <= em;
        opnd_start <= st;
        opnd_last <= la;
        issue(fxc_pkg::OP_ARITH, fxc_pkg::CL_NORMAL, fxc_pkg::PR_EXT);
        `CHK(fault_valid, 1'b1)
        `CHK(fault_vec, vec)
        `CHK(busy, 1'b0)
    endtask
    initial begin
        {task_switched_flag, emulation_flag, prot_mode, wait_req, go, sw_clear} = 6'h00;
        {opnd_sign, has_prefix, stack_err, ovf_mask, unf_mask, ovf_evt, unf_evt} = 7'h00;
        esc_op = fxc_pkg::OP_ARITH;
        opnd_class = fxc_pkg::CL_NORMAL;
        opnd_prec = fxc_pkg::PR_EXT;
        {round_ctl, tag_idx, tag_wdata, tag_actual} = 9'h01C;
        {opnd_start, opnd_last, seg_limit} = 48'h0010_0011_00FF;
        {instr_addr, prefix_addr} = 32'h1234_1230;
        opcode_in = 11'h1AB;
        rst_n = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        `CHK(busy, 1'b0)
        `CHK(issue_ready, 1'b1)
        `CHK(status_word, fxc_pkg::SW_RESET)
        `CHK(tag_word, 16'hFFFF)
        fault_case(1'b1, 1'b0, 16'h0010, 16'h0011, fxc_pkg::VEC_UNAVAIL);
        fault_case(1'b0, 1'b1, 16'h0010, 16'h0011, fxc_pkg::VEC_UNAVAIL);
        fault_case(1'b0, 1'b0, 16'h0100, 16'h0101, fxc_pkg::VEC_GEN_PROT);
        fault_case(1'b0, 1'b0, 16'h00FF, 16'h0100, fxc_pkg::VEC_SEG_OVERRUN);
        @(posedge ref_clk);
        {opnd_start, opnd_last} <= 32'h0010_0011;
        task_switched_flag <= 1'b1;
        wait_req <= 1'b1;
        @(posedge ref_clk);
        wait_req <= 1'b0;
        task_switched_flag <= 1'b0;
        @(negedge ref_clk);
        `CHK(fault_valid, 1'b1)
        `CHK(fault_vec, fxc_pkg::VEC_UNAVAIL)
        issue(fxc_pkg::OP_ARITH, fxc_pkg::CL_NORMAL, fxc_pkg::PR_EXT);
        `CHK(busy, 1'b1)
        t0 = cyc;
        issue(fxc_pkg::OP_ARITH, fxc_pkg::CL_NORMAL, fxc_pkg::PR_EXT);
        `CHK(cyc - t0, 6)
        n = 0;
        while (busy === 1'b1 && n < 10) begin
            n++;
            @(negedge ref_clk);
        end
        `CHK(n, 5)
        for (int i = 0; i < 13; i++) begin
            clear();
            @(posedge ref_clk);
            stack_err <= NUMS[i].se;
            issue(NUMS[i].op, NUMS[i].cl, NUMS[i].pr);
            `CHK(status_word, NUMS[i].sw)
        end
        `CHK(saved_ip, 16'h1234)
        @(posedge ref_clk);
        has_prefix <= 1'b1;
        issue(fxc_pkg::OP_ARITH, fxc_pkg::CL_NORMAL, fxc_pkg::PR_EXT);
        `CHK(saved_ip, 16'h1230)
        `CHK(saved_opcode, 11'h1AB)
        `CHK(saved_layout, fxc_pkg::LAYOUT_REAL)
        @(posedge ref_clk);
        prot_mode <= 1'b1;
        issue(fxc_pkg::OP_ENV_STORE, fxc_pkg::CL_NORMAL, fxc_pkg::PR_EXT);
        `CHK(saved_layout, fxc_pkg::LAYOUT_PROT)
        @(posedge ref_clk);
        prot_mode <= 1'b0;
        issue(fxc_pkg::OP_STATE_SAVE, fxc_pkg::CL_NORMAL, fxc_pkg::PR_EXT);
        `CHK(saved_layout, fxc_pkg::LAYOUT_REAL)
        @(posedge ref_clk);
        prot_mode <= 1'b1;
        opcode_in <= 11'h2CD;
        issue(fxc_pkg::OP_ARITH, fxc_pkg::CL_NORMAL, fxc_pkg::PR_EXT);
        `CHK(saved_opcode, 11'h000)
        `CHK(saved_layout, fxc_pkg::LAYOUT_PROT)
        for (int i = 0; i < 3; i++) begin
            clear();
            @(posedge ref_clk);
            prefix_addr <= 16'h5A5A;
            prot_mode <= 1'b0;
            issue(NOPS[i], fxc_pkg::CL_SNAN, fxc_pkg::PR_EXT);
            `CHK(status_word, 8'h00)
            `CHK({saved_ip, saved_layout}, {16'h1230, fxc_pkg::LAYOUT_PROT})
        end
        clear();
        issue(fxc_pkg::OP_SPLIT, fxc_pkg::CL_ZERO, fxc_pkg::PR_EXT);
        `CHK(status_word, 8'h04)
        `CHK(st1_hi, fxc_pkg::NEG_INF_HI)
        for (int s = 0; s < 2; s++) begin
            @(posedge ref_clk);
            opnd_sign <= s[0];
            issue(fxc_pkg::OP_ARITH, fxc_pkg::CL_INF, fxc_pkg::PR_EXT);
            `CHK(st1_hi, s[0] ? fxc_pkg::NEG_INF_HI : fxc_pkg::POS_INF_HI)
        end
        for (int r = 3; r >= 0; r--) begin
            @(posedge ref_clk);
            round_ctl <= 2'(r);
            issue(fxc_pkg::OP_LOAD_CONST, fxc_pkg::CL_NORMAL, fxc_pkg::PR_EXT);
            `CHK(const_round, 2'(r))
        end
        @(posedge ref_clk);
        {ovf_mask, ovf_evt, round_ctl} <= 4'hE;
        issue(fxc_pkg::OP_ARITH, fxc_pkg::CL_NORMAL, fxc_pkg::PR_EXT);
        `CHK(result_round, 2'h2)
        @(posedge ref_clk);
        {ovf_evt, unf_mask, unf_evt, round_ctl} <= 5'h0D;
        issue(fxc_pkg::OP_ARITH, fxc_pkg::CL_NORMAL, fxc_pkg::PR_EXT);
        `CHK(result_round, 2'h1)
        `CHK(status_word, 8'h1C)
        @(posedge ref_clk);
        tag_actual <= fxc_pkg::TAG_ZERO;
        tag_wdata <= fxc_pkg::TAG_VALID;
        issue(fxc_pkg::OP_TAG_WRITE, fxc_pkg::CL_NORMAL, fxc_pkg::PR_EXT);
        `CHK(tag_word, 16'hFFF7)
        @(posedge ref_clk);
        tag_wdata <= fxc_pkg::TAG_EMPTY;
        issue(fxc_pkg::OP_TAG_WRITE, fxc_pkg::CL_NORMAL, fxc_pkg::PR_EXT);
        `CHK(tag_word, 16'hFFFF)
        give_verdict();
    end
endmodule
`default_nettype wire
